// ==== logic/dsl_pkg.sv ====
// Purpose: Shared constants for the serial load link of the sixteen channel converter.
// Assumes: A 10 MHz system clock on both ends.
// Notes:   Word layout and command codes are fixed here for both ends.
package dsl_pkg;
    localparam int WORD_BITS  = 24;
    localparam int CHANNELS   = 16;
    localparam int DATA_BITS  = 16;
    localparam int CMD_MSB    = 23;
    localparam int CMD_LSB    = 20;
    localparam int ADDR_MSB   = 19;
    localparam int ADDR_LSB   = 16;
    localparam int DATA_MSB   = 15;

    localparam logic [3:0] CMD_WR_INPUT  = 4'h1;
    localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
    localparam logic [3:0] CMD_READBACK  = 4'h9;

    localparam logic [15:0] ZERO_SCALE = 16'h0000;
    localparam logic [15:0] MID_SCALE  = 16'h8000;

    localparam int SYS_PERIOD_NS = 100;
    localparam int SCLK_MAX_MHZ  = 50;
    localparam int SCLK_MIN_NS   = 1000 / SCLK_MAX_MHZ;
    localparam int LOAD_LOW_NS   = 12;

    // Least times round up and never fall below one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SCLK_MIN_HALF_CYC = min_cycles(SCLK_MIN_NS / 2);
    localparam int SCLK_HALF_CYC     = 8;
    localparam int LOAD_LOW_CYC      = min_cycles(LOAD_LOW_NS);

    typedef enum logic [1:0] {
        DSL_IDLE,
        DSL_SHIFT,
        DSL_TRAIL,
        DSL_GAP
    } dsl_host_state_t;
endpackage

// ==== logic/dsl_link_if.sv ====
// Purpose: Pin level link between the host end and the converter end.
// Assumes: Serial clock idles high between frames.
// Notes:   Serial out reads low while the converter does not drive it.
`timescale 1ns/1ps
interface dsl_link_if;
    logic frame_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;
    logic output_load_n;
    logic hw_reset_n;
    logic gain_x2;

    assign sdo_line = sdo_oe & sdo;

    modport device (
        input  frame_n,
        input  sclk,
        input  sdi,
        input  output_load_n,
        input  hw_reset_n,
        input  gain_x2,
        output sdo,
        output sdo_oe
    );

    modport host (
        output frame_n,
        output sclk,
        output sdi,
        output output_load_n,
        output hw_reset_n,
        output gain_x2,
        input  sdo_line
    );
endinterface

// ==== logic/dsl_device_end.sv ====
// Purpose: Converter end: serial input, readback, input and converter registers.
// Assumes: Every link pin is asynchronous to SYS_CLK_IN and is synchronised.
// Notes:   Serial clock must stay below a quarter of the system clock rate.
`timescale 1ns/1ps
// Overview of operation
// - Input accepted only while frame select low
// - Take 24 falling-edge bits after frame falls
// - Sample serial input on falling serial edges
// - Host keeps serial clock at most 50 MHz
// - Incoming word held in 24-bit shift register
// - Pulsed load mode, or update with serial write
// - Load pulse moves all fresh channels together
// - Load pin may be held low permanently
// - Output shifts on rise, sampled on fall
// - Serial output serves daisy chain or readback
// - Hardware reset acts on its falling edge
// - Load pulses ignored while hardware reset low
// - Reset loads zero or midscale per variant
// - Gain pin selects one or two span
module dsl_device_end #(
    parameter int CHANNELS  = dsl_pkg::CHANNELS,
    parameter bit MIDSCALE  = 1'b0
) (
    input  wire logic                                SYS_CLK_IN,
    input  wire logic                                RST_N_IN,
    dsl_link_if.device                               LINK,
    output logic [CHANNELS*dsl_pkg::DATA_BITS-1:0]   CHANNEL_OUTPUT_OUT,
    output logic [CHANNELS-1:0]                      INPUT_PENDING_OUT,
    output logic                                     GAIN_X2_OUT
);
    localparam int DW = dsl_pkg::DATA_BITS;
    localparam int WW = dsl_pkg::WORD_BITS;
    // Bit count stops at a full word so extra edges cannot wrap it
    localparam logic [4:0] COUNT_FULL = 5'(dsl_pkg::WORD_BITS);
    // Reset code is fixed per build variant
    localparam logic [DW-1:0] RESET_CODE = MIDSCALE ? dsl_pkg::MID_SCALE
                                                     : dsl_pkg::ZERO_SCALE;

    typedef struct packed {
        logic [2:0]                  frame_s;
        logic [2:0]                  sclk_s;
        logic [2:0]                  load_s;
        logic [2:0]                  hwrst_s;
        logic [1:0]                  sdi_s;
        logic [1:0]                  gain_s;
        logic [WW-1:0]               shift;
        logic [4:0]                  count;
        logic                        sdo;
        logic                        sdo_oe;
        logic [CHANNELS-1:0][DW-1:0] input_regs;
        logic [CHANNELS-1:0][DW-1:0] dac_regs;
        logic [CHANNELS-1:0]         fresh;
    } dsl_dev_state_t;

    dsl_dev_state_t state_reg;
    dsl_dev_state_t state_next;

    function automatic logic fell2(input logic [2:0] s);
        return s[2] & ~s[1];
    endfunction

    function automatic logic rose2(input logic [2:0] s);
        return ~s[2] & s[1];
    endfunction

    // Field positions live in the package so both ends agree
    function automatic logic [3:0] word_cmd(input logic [WW-1:0] w);
        return w[dsl_pkg::CMD_MSB:dsl_pkg::CMD_LSB];
    endfunction

    function automatic logic [3:0] word_addr(input logic [WW-1:0] w);
        return w[dsl_pkg::ADDR_MSB:dsl_pkg::ADDR_LSB];
    endfunction

    function automatic logic [DW-1:0] word_data(input logic [WW-1:0] w);
        return w[dsl_pkg::DATA_MSB:0];
    endfunction

    // Pin levels and edges seen after the synchronisers
    logic          frame_low;
    logic          frame_fall;
    logic          frame_rise;
    logic          sclk_fall;
    logic          sclk_rise;
    logic          load_low;
    logic          load_fall;
    logic          hwrst_low;
    logic          hwrst_fall;

    // Fields of the word now in the shift register
    logic [3:0]    cmd;
    logic [3:0]    addr;
    logic [DW-1:0] data;

    // Edge detectors read the second stage and its history only
    assign frame_low  = ~state_reg.frame_s[1];
    assign frame_fall = fell2(state_reg.frame_s);
    assign frame_rise = rose2(state_reg.frame_s);

    assign sclk_fall  = fell2(state_reg.sclk_s);
    assign sclk_rise  = rose2(state_reg.sclk_s);

    assign load_low   = ~state_reg.load_s[1];
    assign load_fall  = fell2(state_reg.load_s);
    assign hwrst_low  = ~state_reg.hwrst_s[1];
    assign hwrst_fall = fell2(state_reg.hwrst_s);

    assign cmd        = word_cmd(state_reg.shift);
    assign addr       = word_addr(state_reg.shift);
    assign data       = word_data(state_reg.shift);

    always_comb begin
        state_next = state_reg;
        // Every pin is sampled each cycle; only stage two and its history feed logic
        state_next.frame_s = {state_reg.frame_s[1:0], LINK.frame_n};
        state_next.sclk_s  = {state_reg.sclk_s[1:0], LINK.sclk};
        state_next.load_s  = {state_reg.load_s[1:0], LINK.output_load_n};
        state_next.hwrst_s = {state_reg.hwrst_s[1:0], LINK.hw_reset_n};
        state_next.sdi_s   = {state_reg.sdi_s[0], LINK.sdi};
        state_next.gain_s  = {state_reg.gain_s[0], LINK.gain_x2};
        // Output is driven only inside a frame so chained parts can share it
        state_next.sdo_oe  = frame_low;

        if (frame_fall) begin
            state_next.count = 5'h00;
            state_next.sdo   = state_reg.shift[WW-1];
        end else if (frame_low && sclk_fall && state_reg.count < COUNT_FULL) begin
            // Edges past the 24th are ignored until the next frame
            state_next.shift = {state_reg.shift[WW-2:0], state_reg.sdi_s[1]};
            state_next.count = state_reg.count + 5'h01;
        end else if (frame_low && sclk_rise) begin
            state_next.sdo = state_reg.shift[WW-1];
        end

        // Pulsed load, ignored while the reset pin is low
        // Only channels holding fresh input data are copied
        if (load_fall && !hwrst_low) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (state_reg.fresh[ch]) begin
                    state_next.dac_regs[ch] = state_reg.input_regs[ch];
                    state_next.fresh[ch]    = 1'b0;
                end
            end
        end

        // A short frame is dropped; the decode wins over a load in the same cycle
        // Unknown commands and channels fall through untouched
        if (frame_rise && state_reg.count == COUNT_FULL && 32'(addr) < CHANNELS) begin
            if (cmd == dsl_pkg::CMD_WR_INPUT) begin
                state_next.input_regs[addr] = data;
                // A load pin held low means update with the write itself
                if (load_low && !hwrst_low) begin
                    state_next.dac_regs[addr] = data;
                    state_next.fresh[addr]    = 1'b0;
                end else begin
                    state_next.fresh[addr] = 1'b1;
                end
            end else if (cmd == dsl_pkg::CMD_WR_UPDATE) begin
                state_next.input_regs[addr] = data;
                state_next.dac_regs[addr]   = data;
                state_next.fresh[addr]      = 1'b0;
            end else if (cmd == dsl_pkg::CMD_READBACK) begin
                // Shifted out during the following frame
                state_next.shift = {{(WW-DW){1'b0}}, state_reg.input_regs[addr]};
            end
        end

        // Reset pin falling edge overrides every channel register update in its cycle
        // Serial state is kept, so a frame in flight still completes
        if (hwrst_fall) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                state_next.input_regs[ch] = RESET_CODE;
                state_next.dac_regs[ch]   = RESET_CODE;
            end
            state_next.fresh = '0;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            // Synchronisers start at idle pin levels: no false edge after reset
            state_reg.frame_s    <= 3'h7;
            state_reg.sclk_s     <= 3'h7;
            state_reg.load_s     <= 3'h7;
            state_reg.hwrst_s    <= 3'h7;
            state_reg.sdi_s      <= 2'h0;
            state_reg.gain_s     <= 2'h0;

            state_reg.shift      <= '0;
            state_reg.count      <= 5'h00;
            state_reg.sdo        <= 1'b0;
            state_reg.sdo_oe     <= 1'b0;
            state_reg.input_regs <= {CHANNELS{RESET_CODE}};
            state_reg.dac_regs   <= {CHANNELS{RESET_CODE}};
            state_reg.fresh      <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register
    assign LINK.sdo           = state_reg.sdo;
    assign LINK.sdo_oe        = state_reg.sdo_oe;
    assign CHANNEL_OUTPUT_OUT = state_reg.dac_regs;
    assign INPUT_PENDING_OUT  = state_reg.fresh;
    // Span select is a static level passed to the analog side
    assign GAIN_X2_OUT        = state_reg.gain_s[1];
endmodule

// ==== logic/dsl_host_end.sv ====
// Purpose: Host end: queues words and drives frame, serial clock, load and reset pins.
// Assumes: One system clock; the serial clock is divided from it.
// Notes:   Received words carry daisy chain or readback data of the previous frame.
`timescale 1ns/1ps
module dsl_word_fifo #(
    parameter int WIDTH = dsl_pkg::WORD_BITS,
    parameter int DEPTH = 4
) (
    input  wire logic             SYS_CLK_IN,
    input  wire logic             RST_N_IN,
    input  wire logic [WIDTH-1:0] IN_DATA_IN,
    input  wire logic             IN_VALID_IN,
    output logic                  IN_READY_OUT,
    output logic [WIDTH-1:0]      OUT_DATA_OUT,
    output logic                  OUT_VALID_OUT,
    input  wire logic             OUT_READY_IN
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               count;
    } dsl_fifo_state_t;

    dsl_fifo_state_t state_reg;
    dsl_fifo_state_t state_next;
    logic            push;
    logic            pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (32'(p) == DEPTH - 1) ? '0 : p + PW'(1);
    endfunction

    assign IN_READY_OUT  = 32'(state_reg.count) < DEPTH;
    assign OUT_VALID_OUT = state_reg.count != '0;
    assign OUT_DATA_OUT  = state_reg.mem[state_reg.rd];
    assign push          = IN_VALID_IN & IN_READY_OUT;
    assign pop           = OUT_VALID_OUT & OUT_READY_IN;

    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wr] = IN_DATA_IN;
            state_next.wr                = bump(state_reg.wr);
        end
        if (pop) begin
            state_next.rd = bump(state_reg.rd);
        end
        state_next.count = state_reg.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

module dsl_host_end #(
    parameter int HALF_CYC = dsl_pkg::SCLK_HALF_CYC,
    parameter int DEPTH    = 4
) (
    input  wire logic                          SYS_CLK_IN,
    input  wire logic                          RST_N_IN,
    input  wire logic [dsl_pkg::WORD_BITS-1:0] WORD_IN,
    input  wire logic                          WORD_VALID_IN,
    output logic                               WORD_READY_OUT,
    output logic [dsl_pkg::WORD_BITS-1:0]      RX_WORD_OUT,
    output logic                               RX_VALID_OUT,
    input  wire logic                          LOAD_PULSE_IN,
    input  wire logic                          LOAD_HOLD_LOW_IN,
    input  wire logic                          HW_RESET_IN,
    input  wire logic                          GAIN_X2_IN,
    output logic                               BUSY_OUT,
    dsl_link_if.host                           LINK
);
    localparam int WW = dsl_pkg::WORD_BITS;
    localparam logic [5:0] LAST_PHASE = 6'(2 * dsl_pkg::WORD_BITS - 1);
    localparam logic [7:0] HALF_TOP   = 8'(HALF_CYC - 1);
    localparam logic [3:0] LOAD_CYC   = 4'(dsl_pkg::LOAD_LOW_CYC);

    typedef struct packed {
        dsl_pkg::dsl_host_state_t st;
        logic [7:0]               div;
        logic [5:0]               phase;
        logic [WW-1:0]            tx;
        logic [WW-1:0]            rx;
        logic                     rx_valid;
        logic [1:0]               sdo_s;
        logic                     frame_n;
        logic                     sclk;
        logic                     sdi;
        logic [3:0]               load_cnt;
        logic                     load_n;
        logic                     hwrst_n;
        logic                     gain;
    } dsl_host_state_reg_t;

    dsl_host_state_reg_t state_reg;
    dsl_host_state_reg_t state_next;
    logic [WW-1:0]       q_data;
    logic                q_valid;
    logic                q_take;
    logic                tick;

    dsl_word_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) dsl_word_fifo_inst (
        .SYS_CLK_IN    (SYS_CLK_IN),
        .RST_N_IN      (RST_N_IN),
        .IN_DATA_IN    (WORD_IN),
        .IN_VALID_IN   (WORD_VALID_IN),
        .IN_READY_OUT  (WORD_READY_OUT),
        .OUT_DATA_OUT  (q_data),
        .OUT_VALID_OUT (q_valid),
        .OUT_READY_IN  (q_take)
    );

    // Divider stays within the serial clock ceiling by construction
    assign tick   = state_reg.div == HALF_TOP;
    assign q_take = state_reg.st == dsl_pkg::DSL_IDLE;

    always_comb begin
        state_next          = state_reg;
        state_next.div      = tick ? 8'h00 : state_reg.div + 8'h01;
        state_next.rx_valid = 1'b0;
        state_next.sdo_s    = {state_reg.sdo_s[0], LINK.sdo_line};
        state_next.hwrst_n  = ~HW_RESET_IN;
        state_next.gain     = GAIN_X2_IN;
        if (LOAD_PULSE_IN && state_reg.load_cnt == 4'h0) begin
            state_next.load_cnt = LOAD_CYC;
        end else if (state_reg.load_cnt != 4'h0) begin
            state_next.load_cnt = state_reg.load_cnt - 4'h1;
        end
        state_next.load_n = ~(LOAD_HOLD_LOW_IN | (state_next.load_cnt != 4'h0));
        case (state_reg.st)
            dsl_pkg::DSL_IDLE: begin
                if (q_valid) begin
                    state_next.tx      = q_data;
                    state_next.sdi     = q_data[WW-1];
                    state_next.frame_n = 1'b0;
                    state_next.phase   = 6'h00;
                    state_next.div     = 8'h00;
                    state_next.st      = dsl_pkg::DSL_SHIFT;
                end
            end
            dsl_pkg::DSL_SHIFT: begin
                if (tick) begin
                    if (!state_reg.phase[0]) begin
                        state_next.sclk = 1'b0;
                        state_next.rx   = {state_reg.rx[WW-2:0], state_reg.sdo_s[1]};
                    end else begin
                        state_next.sclk = 1'b1;
                        state_next.tx   = {state_reg.tx[WW-2:0], 1'b0};
                        state_next.sdi  = state_reg.tx[WW-2];
                    end
                    state_next.phase = state_reg.phase + 6'h01;
                    if (state_reg.phase == LAST_PHASE) begin
                        state_next.st = dsl_pkg::DSL_TRAIL;
                    end
                end
            end
            dsl_pkg::DSL_TRAIL: begin
                if (tick) begin
                    state_next.frame_n  = 1'b1;
                    state_next.rx_valid = 1'b1;
                    state_next.st       = dsl_pkg::DSL_GAP;
                end
            end
            default: begin
                if (tick) begin
                    state_next.st = dsl_pkg::DSL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg         <= '0;
            state_reg.st      <= dsl_pkg::DSL_IDLE;
            state_reg.frame_n <= 1'b1;
            state_reg.sclk    <= 1'b1;
            state_reg.load_n  <= 1'b1;
            state_reg.hwrst_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign LINK.frame_n       = state_reg.frame_n;
    assign LINK.sclk          = state_reg.sclk;
    assign LINK.sdi           = state_reg.sdi;
    assign LINK.output_load_n = state_reg.load_n;
    assign LINK.hw_reset_n    = state_reg.hwrst_n;
    assign LINK.gain_x2       = state_reg.gain;
    assign RX_WORD_OUT        = state_reg.rx;
    assign RX_VALID_OUT       = state_reg.rx_valid;
    assign BUSY_OUT           = state_reg.st != dsl_pkg::DSL_IDLE;
endmodule

// ==== tb/dsl_link_properties.sv ====
// Purpose: Concurrent checks on the serial load link between the two ends.
// Assumes: Host serial half period of 8 system cycles.
// Notes:   Latency windows allow for the two flop pin synchronisers.
`timescale 1ns/1ps
module dsl_link_properties (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic frame_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    input wire logic sdo_in,
    input wire logic sdo_oe_in
);
    logic       sclk_q_reg;
    logic [5:0] falls_reg;

    // Counts falling serial edges inside a frame
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sclk_q_reg <= 1'b1;
            falls_reg  <= 6'h00;
        end else begin
            sclk_q_reg <= sclk_in;
            if (frame_n_in)
                falls_reg <= 6'h00;
            else if (sclk_q_reg && !sclk_in)
                falls_reg <= falls_reg + 6'h01;
        end
    end

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_sclk_idle: assert property (frame_n_in && $past(frame_n_in) |-> sclk_in)
        else $error("serial clock moved outside a frame");
    a_frame_gap: assert property ($rose(frame_n_in) |=> frame_n_in [*7])
        else $error("frame gap too short");
    a_fall_count: assert property ($rose(frame_n_in) |-> falls_reg == 6'h18)
        else $error("frame without 24 falling edges");
    a_sdi_setup: assert property (!frame_n_in && $changed(sdi_in) |-> sclk_in)
        else $error("serial input changed while clock low");
    a_sclk_half: assert property (!frame_n_in && $changed(sclk_in)
        |=> $stable(sclk_in) [*3])
        else $error("serial clock half period too short");
    a_sdo_shift: assert property (!frame_n_in && !$past(frame_n_in)
        && $changed(sdo_in) |-> sclk_in)
        else $error("serial output changed while clock low");
    a_sdo_enable: assert property ($fell(frame_n_in) |-> ##[1:4] sdo_oe_in)
        else $error("serial output not enabled in frame");
    a_sdo_release: assert property ($rose(frame_n_in) |-> ##[1:4] !sdo_oe_in)
        else $error("serial output not released after frame");
endmodule

// ==== tb/test_dac_serial_load_control.sv ====
// Purpose: Self-checking bench joining the host end and the converter end.
// Assumes: Serial half period 8 cycles, zero scale reset variant.
// Notes:   Received words are queued on the falling edge to avoid races.
`timescale 1ns/1ps
module test_dac_serial_load_control;
    localparam logic [3:0] WR = dsl_pkg::CMD_WR_INPUT;
    localparam logic [3:0] WU = dsl_pkg::CMD_WR_UPDATE;
    localparam logic [3:0] RB = dsl_pkg::CMD_READBACK;
    logic         sys_clk;
    logic         rst_n;
    logic [23:0]  word;
    logic         word_valid;
    logic         word_ready;
    logic [23:0]  rx_word;
    logic         rx_valid;
    logic         load_pulse;
    logic         load_hold;
    logic         hw_reset;
    logic         gain_x2;
    logic         busy;
    logic [255:0] chan;
    logic [15:0]  pending;
    logic         gain_out;
    logic [23:0]  rxq[$];
    logic         saw_full;
    int           n_fail = 0;
    int           n_tests = 0;

    dsl_link_if dsl_link_if_inst ();
    dsl_host_end #(.HALF_CYC(8), .DEPTH(4)) dsl_host_end_inst (
        .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .WORD_IN(word),
        .WORD_VALID_IN(word_valid), .WORD_READY_OUT(word_ready),
        .RX_WORD_OUT(rx_word), .RX_VALID_OUT(rx_valid), .LOAD_PULSE_IN(load_pulse),
        .LOAD_HOLD_LOW_IN(load_hold), .HW_RESET_IN(hw_reset), .GAIN_X2_IN(gain_x2),
        .BUSY_OUT(busy), .LINK(dsl_link_if_inst));
    dsl_device_end #(.CHANNELS(16), .MIDSCALE(1'b0)) dsl_device_end_inst (
        .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .LINK(dsl_link_if_inst),
        .CHANNEL_OUTPUT_OUT(chan), .INPUT_PENDING_OUT(pending), .GAIN_X2_OUT(gain_out));
    dsl_link_properties dsl_link_properties_inst (
        .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .frame_n_in(dsl_link_if_inst.frame_n),
        .sclk_in(dsl_link_if_inst.sclk), .sdi_in(dsl_link_if_inst.sdi),
        .sdo_in(dsl_link_if_inst.sdo), .sdo_oe_in(dsl_link_if_inst.sdo_oe));

    function automatic logic [15:0] ch(input int n);
        return chan[16*n +: 16];
    endfunction
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic send(input logic [23:0] w);
        @(negedge sys_clk);
        word = w;
        word_valid = 1'b1;
        while (word_ready !== 1'b1) begin
            saw_full = 1'b1;
            @(negedge sys_clk);
        end
        @(negedge sys_clk);
        word_valid = 1'b0;
    endtask
    // Waits for the frame end, then lets the decode land
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        int i;
        send(w);
        for (i = 0; i < 600 && rxq.size() == 0; i++) @(negedge sys_clk);
        r = (rxq.size() != 0) ? rxq.pop_front() : 24'hxxxxxx;
        repeat (6) @(negedge sys_clk);
    endtask
    // Stops early once channel c shows v, so the joint update is seen at once
    task automatic pulse(input int c, input logic [15:0] v);
        int i;
        @(negedge sys_clk);
        load_pulse = 1'b1;
        @(negedge sys_clk);
        load_pulse = 1'b0;
        for (i = 0; i < 8 && ch(c) !== v; i++) @(negedge sys_clk);
    endtask

    task automatic t_reset;
        int i;
        for (i = 0; i < 16; i++) chk(ch(i), dsl_pkg::ZERO_SCALE, "reset ch");
        chk(pending, 16'h0000, "reset pending");
        $display("test reset done");
    endtask
    task automatic t_async;
        logic [23:0] r;
        xfer({WR, 4'h3, 16'h1234}, r);
        xfer({WR, 4'h5, 16'habcd}, r);
        chk(pending, 16'h0028, "pending pair");
        chk(ch(3), 16'h0000, "held ch");
        pulse(3, 16'h1234);
        chk(ch(5), 16'habcd, "joint update");
        chk(ch(3), 16'h1234, "load ch");
        chk(pending, 16'h0000, "pending clear");
        $display("test async done");
    endtask
    task automatic t_sync;
        logic [23:0] r;
        xfer({WU, 4'h0, 16'h5a5a}, r);
        chk(ch(0), 16'h5a5a, "write update");
        load_hold = 1'b1;
        xfer({WR, 4'hf, 16'h0f0f}, r);
        chk(ch(15), 16'h0f0f, "held low ch");
        chk(pending, 16'h0000, "held low pending");
        load_hold = 1'b0;
        $display("test sync done");
    endtask
    task automatic t_chain;
        logic [23:0] r;
        xfer(24'h0c1e5a, r);
        xfer(24'h0a5a5a, r);
        chk(r, 24'h0c1e5a, "chained word");
        xfer({RB, 4'h3, 16'h0000}, r);
        xfer(24'h000000, r);
        chk(r, 24'h001234, "readback");
        chk(ch(0), 16'h5a5a, "ignored cmd");
        chk(ch(10), 16'h0000, "ignored cmd ch");
        chk(pending, 16'h0000, "ignored cmd pending");
        $display("test chain done");
    endtask
    task automatic t_hwreset;
        logic [23:0] r;
        xfer({WR, 4'h2, 16'h2222}, r);
        hw_reset = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(ch(3), 16'h0000, "pin reset ch");
        chk(pending, 16'h0000, "pin reset pending");
        xfer({WR, 4'h2, 16'h3333}, r);
        pulse(2, 16'h3333);
        chk(ch(2), 16'h0000, "load in reset");
        chk(pending, 16'h0004, "pending kept");
        hw_reset = 1'b0;
        repeat (6) @(negedge sys_clk);
        pulse(2, 16'h3333);
        chk(ch(2), 16'h3333, "load after reset");
        $display("test hwreset done");
    endtask
    task automatic t_gain;
        gain_x2 = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk(gain_out, 1'b1, "gain high");
        gain_x2 = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk(gain_out, 1'b0, "gain low");
        $display("test gain done");
    endtask
    // Four queued behind a running frame: the sixth must wait
    task automatic t_fifo;
        int i;
        saw_full = 1'b0;
        for (i = 1; i < 7; i++) send(24'(i));
        chk(saw_full, 1'b1, "queue full");
        chk(busy, 1'b1, "busy");
        for (i = 0; i < 3000 && rxq.size() < 6; i++) @(negedge sys_clk);
        for (i = 1; i < 6; i++) chk(rxq[i], 24'(i), "queue order");
        repeat (12) @(negedge sys_clk);
        chk(busy, 1'b0, "idle");
        $display("test fifo done");
    endtask

    task automatic close_out;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) if (rx_valid === 1'b1) rxq.push_back(rx_word);
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        word = 24'h000000;
        word_valid = 1'b0;
        load_pulse = 1'b0;
        load_hold = 1'b0;
        hw_reset = 1'b0;
        gain_x2 = 1'b0;
        saw_full = 1'b0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_async();
        t_sync();
        t_chain();
        t_hwreset();
        t_gain();
        t_fifo();
        close_out();
    end
endmodule
